/* logic/tmc_pkg.sv */
// Shared constants for the timer 0/1 mode 0 and clock select block
package tmc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RUN_FLAG   = 8'h88;
  localparam logic [7:0] IDX_MODE       = 8'h89;
  localparam logic [7:0] IDX_T0_LOW     = 8'h8A;
  localparam logic [7:0] IDX_T1_LOW     = 8'h8B;
  localparam logic [7:0] IDX_T0_HIGH    = 8'h8C;
  localparam logic [7:0] IDX_T1_HIGH    = 8'h8D;
  localparam logic [7:0] IDX_CLK_CTRL   = 8'h8E;
  localparam logic [7:0] IDX_IRQ_CONFIG = 8'h8F;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h90;
  localparam logic [7:0] RESET_BYTE     = 8'h00;

  // timer_clock_control fields
  localparam int CK_T3H = 7;
  localparam int CK_T3L = 6;
  localparam int CK_T2H = 5;
  localparam int CK_T2L = 4;
  localparam int CK_T1  = 3;
  localparam int CK_T0  = 2;
  localparam logic [1:0] PRE_DIV12 = 2'h0;
  localparam logic [1:0] PRE_DIV4  = 2'h1;
  localparam logic [1:0] PRE_DIV48 = 2'h2;
  localparam logic [1:0] PRE_EXT8  = 2'h3;

  // timer_run_flag_reg fields
  localparam int RF_FLAG1 = 7;
  localparam int RF_RUN1  = 6;
  localparam int RF_FLAG0 = 5;
  localparam int RF_RUN0  = 4;

  // timer_mode_reg fields, timer 1 sits 4 bits above timer 0
  localparam int MD_T1_BASE = 4;
  localparam int MD_CNT_SEL = 2;
  localparam int MD_GATE    = 3;
  localparam logic [1:0] MODE_13BIT = 2'h0;

  // Prescaler counts, 13-bit count maximum and APB address width
  localparam logic [5:0] PRE_WRAP      = 6'h2F;
  localparam logic [5:0] PRE_D12_MOD   = 6'h0C;
  localparam logic [5:0] PRE_D12_LAST  = 6'h0B;
  localparam logic [1:0] PRE_D4_LAST   = 2'h3;
  localparam logic [2:0] EXT_DIV_LAST  = 3'h7;
  localparam logic [12:0] COUNT13_MAX  = 13'h1FFF;
  localparam int ADDR_W = 12;
endpackage

/* logic/tmc_timer13.sv */
// One 13-bit counter/timer with its count pin edge detector
`timescale 1ns/1ns
`default_nettype none
module tmc_timer13 (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       count_select,
  input  wire logic       count_pin,
  input  wire logic       run_en,
  input  wire logic       wr_low,
  input  wire logic       wr_high,
  input  wire logic [7:0] wdata,
  output logic      [7:0] low_byte,
  output logic      [7:0] high_byte,
  output logic            ovf
);
  typedef struct packed {
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_prev;
    logic [7:0] low;
    logic [7:0] high;
    logic       ovf;
  } tmc_t13_t;

  tmc_t13_t st;
  tmc_t13_t next_st;
  logic        fall;
  logic        inc;
  logic [12:0] count;
  logic [12:0] next_count;

  assign count = {st.high, st.low[4:0]};
  assign fall  = st.pin_prev & ~st.pin_s2;
  assign inc   = run_en & (count_select ? fall : tick);
  assign next_count = count + 13'h0001;

  always_comb begin
    next_st          = st;
    next_st.pin_s1   = count_pin;
    next_st.pin_s2   = st.pin_s1;
    next_st.pin_prev = st.pin_s2;
    next_st.ovf      = 1'b0;
    if (inc) begin
      // Top three low bits are left alone; they carry no count
      next_st.low[4:0] = next_count[4:0];
      next_st.high     = next_count[12:5];
      next_st.ovf      = (count == tmc_pkg::COUNT13_MAX);
    end
    // Software load wins over a same-cycle increment; no clear on run
    if (wr_low) begin
      next_st.low = wdata;
      next_st.ovf = 1'b0;
    end
    if (wr_high) begin
      next_st.high = wdata;
      next_st.ovf  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign low_byte  = st.low;
  assign high_byte = st.high;
  assign ovf       = st.ovf;

  a_hold_stopped: assert property (@(posedge clk) disable iff (rst)
    (!run_en && !wr_low && !wr_high) |=> $stable(count))
    else $error("timer moved while stopped");
  a_roll_over: assert property (@(posedge clk) disable iff (rst)
    (inc && count == 13'h1FFF && !wr_low && !wr_high) |=> (ovf && count == 13'h0000))
    else $error("13-bit rollover missed");
  a_edge_pulse: assert property (@(posedge clk) disable iff (rst)
    fall |=> !fall)
    else $error("edge pulse longer than one cycle");
  a_count_step: assert property (@(posedge clk) disable iff (rst)
    (inc && !wr_low && !wr_high) |=> count == $past(count) + 13'h0001)
    else $error("count did not step by one");
endmodule
`default_nettype wire

/* logic/tmc_top.sv */
// Timer 0/1 13-bit mode, shared prescaler and timer clock selects
`timescale 1ns/1ns
`default_nettype none
module tmc_top (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EXT_OSC,
  input  wire logic        TMR0_COUNT_PIN,
  input  wire logic        TMR1_COUNT_PIN,
  input  wire logic        EXT_IRQ_IN_A,
  input  wire logic        EXT_IRQ_IN_B,
  input  wire logic        TMR0_IRQ_ACK,
  input  wire logic        TMR1_IRQ_ACK,
  input  wire logic        TMR2_EXT_SOURCE_SEL,
  input  wire logic        TMR3_EXT_SOURCE_SEL,
  input  wire logic        TMR2_SPLIT,
  input  wire logic        TMR3_SPLIT,
  output logic             TMR0_IRQ,
  output logic             TMR1_IRQ,
  output logic             TMR2_LOW_TICK,
  output logic             TMR2_HIGH_TICK,
  output logic             TMR3_LOW_TICK,
  output logic             TMR3_HIGH_TICK
);
  typedef struct packed {
    logic [7:0]  clk_ctrl;
    logic [7:0]  mode;
    logic        run0;
    logic        run1;
    logic        flag0;
    logic        flag1;
    logic [1:0]  polarity;
    logic [1:0]  irq_en;
    logic [5:0]  pre_cnt;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_prev;
    logic [2:0]  osc_cnt;
    logic        ext_tick;
    logic        div12_tick;
    logic        pre_tick;
    logic        t2l;
    logic        t2h;
    logic        t3l;
    logic        t3h;
    logic        irq0;
    logic        irq1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tmc_top_t;

  tmc_top_t st;
  tmc_top_t next_st;

  logic [7:0] idx;
  logic       mapped;
  logic       acc;
  logic       wr;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic [7:0] t0_low;
  logic [7:0] t0_high;
  logic [7:0] t1_low;
  logic [7:0] t1_high;
  logic       t0_ovf;
  logic       t1_ovf;
  logic       tick0;
  logic       tick1;
  logic       run_en0;
  logic       run_en1;
  logic       gate_in0;
  logic       gate_in1;
  logic [3:0] md0;
  logic [3:0] md1;
  logic       wr_t0l;
  logic       wr_t0h;
  logic       wr_t1l;
  logic       wr_t1h;
  logic       wr_rf;
  logic       src2;
  logic       src3;

  // APB decode: word aligned, index in address bits 9..2
  assign idx    = PADDR[9:2];
  assign mapped = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0) &&
                  (idx >= tmc_pkg::IDX_RUN_FLAG) && (idx <= tmc_pkg::IDX_IRQ_ENABLE);
  assign acc    = PSEL & PENABLE & st.pready;
  assign wr     = acc & PWRITE & mapped;
  assign wbyte  = PWDATA[7:0];
  assign wr_t0l = wr && idx == tmc_pkg::IDX_T0_LOW;
  assign wr_t0h = wr && idx == tmc_pkg::IDX_T0_HIGH;
  assign wr_t1l = wr && idx == tmc_pkg::IDX_T1_LOW;
  assign wr_t1h = wr && idx == tmc_pkg::IDX_T1_HIGH;
  assign wr_rf  = wr && idx == tmc_pkg::IDX_RUN_FLAG;

  // Per-timer mode nibbles
  assign md0 = st.mode[3:0];
  assign md1 = st.mode[tmc_pkg::MD_T1_BASE +: 4];

  // Gate input active level follows its polarity bit, 1 = high
  assign gate_in0 = st.polarity[0] ? EXT_IRQ_IN_A : ~EXT_IRQ_IN_A;
  assign gate_in1 = st.polarity[1] ? EXT_IRQ_IN_B : ~EXT_IRQ_IN_B;
  // Only mode 0 counts here; other modes hold the count
  assign run_en0 = st.run0 && md0[1:0] == tmc_pkg::MODE_13BIT &&
                   (!md0[tmc_pkg::MD_GATE] || gate_in0);
  assign run_en1 = st.run1 && md1[1:0] == tmc_pkg::MODE_13BIT &&
                   (!md1[tmc_pkg::MD_GATE] || gate_in1);

  // Timer tick: sysclk every cycle or the shared prescaled pulse
  assign tick0 = st.clk_ctrl[tmc_pkg::CK_T0] | st.pre_tick;
  assign tick1 = st.clk_ctrl[tmc_pkg::CK_T1] | st.pre_tick;

  // Timer 2/3 own source: 0 = sysclk/12, 1 = external/8
  assign src2 = TMR2_EXT_SOURCE_SEL ? st.ext_tick : st.div12_tick;
  assign src3 = TMR3_EXT_SOURCE_SEL ? st.ext_tick : st.div12_tick;

  tmc_timer13 u_tmr0 (
    .clk          (CLK),
    .rst          (RST),
    .tick         (tick0),
    .count_select (md0[tmc_pkg::MD_CNT_SEL]),
    .count_pin    (TMR0_COUNT_PIN),
    .run_en       (run_en0),
    .wr_low       (wr_t0l),
    .wr_high      (wr_t0h),
    .wdata        (wbyte),
    .low_byte     (t0_low),
    .high_byte    (t0_high),
    .ovf          (t0_ovf)
  );

  tmc_timer13 u_tmr1 (
    .clk          (CLK),
    .rst          (RST),
    .tick         (tick1),
    .count_select (md1[tmc_pkg::MD_CNT_SEL]),
    .count_pin    (TMR1_COUNT_PIN),
    .run_en       (run_en1),
    .wr_low       (wr_t1l),
    .wr_high      (wr_t1h),
    .wdata        (wbyte),
    .low_byte     (t1_low),
    .high_byte    (t1_high),
    .ovf          (t1_ovf)
  );

  // Read mux
  always_comb begin
    case (idx)
      tmc_pkg::IDX_RUN_FLAG:   rd_byte = {st.flag1, st.run1, st.flag0, st.run0, 4'h0};
      tmc_pkg::IDX_MODE:       rd_byte = st.mode;
      tmc_pkg::IDX_T0_LOW:     rd_byte = t0_low;
      tmc_pkg::IDX_T1_LOW:     rd_byte = t1_low;
      tmc_pkg::IDX_T0_HIGH:    rd_byte = t0_high;
      tmc_pkg::IDX_T1_HIGH:    rd_byte = t1_high;
      tmc_pkg::IDX_CLK_CTRL:   rd_byte = st.clk_ctrl;
      tmc_pkg::IDX_IRQ_CONFIG: rd_byte = {6'h00, st.polarity};
      tmc_pkg::IDX_IRQ_ENABLE: rd_byte = {6'h00, st.irq_en};
      default:                 rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_st = st;

    // Shared prescaler counter, wraps every 48 cycles
    next_st.pre_cnt = (st.pre_cnt == tmc_pkg::PRE_WRAP) ? 6'h00 : st.pre_cnt + 6'h01;
    next_st.div12_tick = (st.pre_cnt % tmc_pkg::PRE_D12_MOD) == tmc_pkg::PRE_D12_LAST;

    // External oscillator: two-flop sync, rising edges divided by 8
    next_st.osc_s1   = EXT_OSC;
    next_st.osc_s2   = st.osc_s1;
    next_st.osc_prev = st.osc_s2;
    next_st.ext_tick = 1'b0;
    if (st.osc_s2 && !st.osc_prev) begin
      next_st.osc_cnt  = st.osc_cnt + 3'h1;
      next_st.ext_tick = (st.osc_cnt == tmc_pkg::EXT_DIV_LAST);
    end

    case (st.clk_ctrl[1:0])
      tmc_pkg::PRE_DIV12: next_st.pre_tick = next_st.div12_tick;
      tmc_pkg::PRE_DIV4:  next_st.pre_tick = st.pre_cnt[1:0] == tmc_pkg::PRE_D4_LAST;
      tmc_pkg::PRE_DIV48: next_st.pre_tick = st.pre_cnt == tmc_pkg::PRE_WRAP;
      tmc_pkg::PRE_EXT8:  next_st.pre_tick = st.ext_tick;
      default:            next_st.pre_tick = 1'b0;
    endcase

    // Timer 2/3 clock enables; high bytes tick in split mode only
    next_st.t2l = st.clk_ctrl[tmc_pkg::CK_T2L] | src2;
    next_st.t2h = TMR2_SPLIT & (st.clk_ctrl[tmc_pkg::CK_T2H] | src2);
    next_st.t3l = st.clk_ctrl[tmc_pkg::CK_T3L] | src3;
    next_st.t3h = TMR3_SPLIT & (st.clk_ctrl[tmc_pkg::CK_T3H] | src3);

    // Register writes
    if (wr) begin
      case (idx)
        tmc_pkg::IDX_MODE:       next_st.mode = wbyte;
        tmc_pkg::IDX_CLK_CTRL:   next_st.clk_ctrl = wbyte;
        tmc_pkg::IDX_IRQ_CONFIG: next_st.polarity = wbyte[1:0];
        tmc_pkg::IDX_IRQ_ENABLE: next_st.irq_en = wbyte[1:0];
        default:                 next_st.mode = st.mode;
      endcase
    end
    if (wr_rf) begin
      next_st.run0  = wbyte[tmc_pkg::RF_RUN0];
      next_st.run1  = wbyte[tmc_pkg::RF_RUN1];
      next_st.flag0 = wbyte[tmc_pkg::RF_FLAG0];
      next_st.flag1 = wbyte[tmc_pkg::RF_FLAG1];
    end
    if (TMR0_IRQ_ACK) begin
      next_st.flag0 = 1'b0;
    end
    if (TMR1_IRQ_ACK) begin
      next_st.flag1 = 1'b0;
    end
    // Overflow set beats any same-cycle clear
    if (t0_ovf) begin
      next_st.flag0 = 1'b1;
    end
    if (t1_ovf) begin
      next_st.flag1 = 1'b1;
    end
    next_st.irq0 = st.flag0 & st.irq_en[0];
    next_st.irq1 = st.flag1 & st.irq_en[1];

    // APB: data prepared in setup so the access phase has no wait
    next_st.pready  = PSEL & ~PENABLE;
    next_st.pslverr = PSEL & ~PENABLE & ~mapped;
    next_st.prdata  = (PSEL && !PENABLE && !PWRITE && mapped) ? {24'h000000, rd_byte} : 32'h00000000;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA         = st.prdata;
  assign PREADY         = st.pready;
  assign PSLVERR        = st.pslverr;
  assign TMR0_IRQ       = st.irq0;
  assign TMR1_IRQ       = st.irq1;
  assign TMR2_LOW_TICK  = st.t2l;
  assign TMR2_HIGH_TICK = st.t2h;
  assign TMR3_LOW_TICK  = st.t3l;
  assign TMR3_HIGH_TICK = st.t3h;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Tick must come from the same prescale setting, not one left over from a switch
  a_div12_period: assert property (
    (st.pre_tick && st.clk_ctrl[1:0] == 2'h0 && $past(st.clk_ctrl[1:0]) == 2'h0) ##1
    (st.clk_ctrl[1:0] == 2'h0) [*8] |-> !st.pre_tick)
    else $error("divide-by-12 tick too early");
  a_div48_gap: assert property (
    (st.pre_tick && st.clk_ctrl[1:0] == 2'h2 && $past(st.clk_ctrl[1:0]) == 2'h2) |->
    ##[1:48] (st.pre_tick || st.clk_ctrl[1:0] != 2'h2))
    else $error("divide-by-48 tick missing");
  a_div4_period: assert property (
    (st.pre_tick && st.clk_ctrl[1:0] == 2'h1 && $past(st.clk_ctrl[1:0]) == 2'h1) ##1
    (st.clk_ctrl[1:0] == 2'h1) [*3] |=> st.pre_tick)
    else $error("divide-by-4 tick missing");
  a_t1_sysclk: assert property (
    st.clk_ctrl[tmc_pkg::CK_T1] |-> tick1)
    else $error("timer 1 tick not on sysclk");
  a_t3_sysclk: assert property (
    st.clk_ctrl[tmc_pkg::CK_T3L] |=> TMR3_LOW_TICK)
    else $error("timer 3 low byte not on sysclk");
  a_t3_high_sys: assert property (
    (TMR3_SPLIT && st.clk_ctrl[tmc_pkg::CK_T3H]) |=> TMR3_HIGH_TICK)
    else $error("timer 3 high byte not on sysclk");
  a_t2_split: assert property (
    !TMR2_SPLIT |=> !TMR2_HIGH_TICK)
    else $error("timer 2 high byte ticked outside split");
  a_irq_masked: assert property (
    !st.irq_en[0] |=> !TMR0_IRQ)
    else $error("timer 0 request while disabled");
  a_mode_hold: assert property (
    (md0[1:0] != tmc_pkg::MODE_13BIT) |-> !run_en0)
    else $error("timer 0 enabled outside 13-bit mode");
  a_t1_flag_set: assert property (
    t1_ovf |=> st.flag1)
    else $error("timer 1 overflow flag missing");
  a_bad_addr: assert property (
    (PSEL && !PENABLE && !mapped) |=> (PREADY && PSLVERR && PRDATA == 32'h00000000))
    else $error("unmapped access not refused");
  a_ext_prescale: assert property (
    (st.clk_ctrl[1:0] == 2'h3 && st.ext_tick) |=> st.pre_tick)
    else $error("external tick not passed to prescaler");
  a_t0_source: assert property (
    (!st.clk_ctrl[2] && !st.pre_tick) |-> !tick0)
    else $error("timer 0 ticked without selected source");
  a_t3_split: assert property (
    !TMR3_SPLIT |=> !TMR3_HIGH_TICK)
    else $error("timer 3 high byte ticked outside split");
  a_t2_sysclk: assert property (
    st.clk_ctrl[4] |=> TMR2_LOW_TICK)
    else $error("timer 2 low byte not on sysclk");
  a_flag_set: assert property (
    t0_ovf |=> st.flag0 ##1 (TMR0_IRQ == st.irq_en[0] || !$past(st.flag0)))
    else $error("overflow flag or request missing");
  a_ack_clear: assert property (
    (TMR1_IRQ_ACK && !t1_ovf && !wr_rf) |=> !st.flag1)
    else $error("flag not cleared on vectoring");
  a_gate_stop: assert property (
    (md0[3] && !gate_in0) |-> !run_en0)
    else $error("gated timer enabled with inactive input");
  a_apb_ready: assert property (
    (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
    else $error("apb ready not one cycle after setup");
endmodule
`default_nettype wire

/* verification/tmc_pin_model.sv */
// Far-side model: count pins, gate inputs and external oscillator
`timescale 1ns/1ns
`default_nettype none
module tmc_pin_model (
  input  wire logic       clk,
  output logic      [1:0] count_pin,
  output logic            gate_a,
  output logic            gate_b,
  output logic            ext_osc
);
  logic [2:0] osc_div;

  initial begin
    count_pin = 2'h3;
    gate_a    = 1'h0;
    gate_b    = 1'h1;
    ext_osc   = 1'h0;
    osc_div   = 3'h0;
  end

  // Oscillator runs free, period of ten system clocks
  always @(posedge clk) begin
    osc_div <= (osc_div == 3'h4) ? 3'h0 : osc_div + 3'h1;
    if (osc_div == 3'h4) begin
      ext_osc <= ~ext_osc;
    end
  end

  // Four clocks per level leaves margin over the sampling minimum
  task automatic pulses(input int t, input int n);
    repeat (n) begin
      @(posedge clk);
      count_pin[t] <= 1'h0;
      repeat (4) @(posedge clk);
      count_pin[t] <= 1'h1;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic set_gates(input logic a, input logic b);
    @(posedge clk);
    gate_a <= a;
    gate_b <= b;
  endtask
endmodule
`default_nettype wire

/* verification/tmc_top_tb_top.sv */
// Testbench: APB access tasks and directed sequences for the timer block
`timescale 1ns/1ns
`default_nettype none
module tmc_top_tb_top;
  logic        CLK;
  logic        RST;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        ext_osc;
  logic [1:0]  count_pin;
  logic        gate_a;
  logic        gate_b;
  logic [1:0]  ack;
  logic [1:0]  irq;
  logic        ext_sel;
  logic        split;
  logic [3:0]  tick;
  logic [31:0] rdv;
  logic        err;
  logic [12:0] cnt;
  logic [7:0]  hb;
  int          failures;
  int          compares;
  int          tc[4];
  int          divs[5] = '{12, 4, 48, 80, 1};
  int          tw[4] = '{48, 48, 480, 480};
  int          tlo[4] = '{48, 48, 40, 6};
  int          thi[4] = '{48, 0, 40, 6};

  tmc_top tmc_top_inst (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_OSC(ext_osc),
    .TMR0_COUNT_PIN(count_pin[0]), .TMR1_COUNT_PIN(count_pin[1]), .EXT_IRQ_IN_A(gate_a),
    .EXT_IRQ_IN_B(gate_b), .TMR0_IRQ_ACK(ack[0]), .TMR1_IRQ_ACK(ack[1]),
    .TMR2_EXT_SOURCE_SEL(ext_sel), .TMR3_EXT_SOURCE_SEL(ext_sel), .TMR2_SPLIT(split),
    .TMR3_SPLIT(split), .TMR0_IRQ(irq[0]), .TMR1_IRQ(irq[1]), .TMR2_LOW_TICK(tick[0]),
    .TMR2_HIGH_TICK(tick[1]), .TMR3_LOW_TICK(tick[2]), .TMR3_HIGH_TICK(tick[3]));

  tmc_pin_model tmc_pin_model_inst (
    .clk(CLK), .count_pin(count_pin), .gate_a(gate_a), .gate_b(gate_b), .ext_osc(ext_osc));

  always #4 CLK = ~CLK;

  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic cmp_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
    compares++;
    if ($isunknown(got) || got < lo || got > hi) begin
      failures++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // Request held until PREADY is seen high at a rising edge
  task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [7:0] d);
    @(posedge CLK);
    PSEL    <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE  <= wr_en;
    PADDR   <= {2'h0, idx, 2'h0};
    PWDATA  <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'h1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'h1);
    rdv = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'h0;
    PENABLE <= 1'h0;
  endtask

  // Low byte bits 7:5 are dropped, they carry no count
  task automatic rd_cnt(input int t);
    apb(1'h0, tmc_pkg::IDX_T0_HIGH + 8'(t), 8'h00);
    hb = rdv[7:0];
    apb(1'h0, tmc_pkg::IDX_T0_LOW + 8'(t), 8'h00);
    cnt = {hb, rdv[4:0]};
  endtask

  task automatic load(input int t, input logic [7:0] h, input logic [7:0] l);
    apb(1'h1, tmc_pkg::IDX_T0_HIGH + 8'(t), h);
    apb(1'h1, tmc_pkg::IDX_T0_LOW + 8'(t), l);
  endtask

  initial begin
    #(8 * 30000);
    failures++;
    final_report();
  end

  initial begin
    CLK = 1'h0;
    RST = 1'h1;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    ack = 2'h0;
    ext_sel = 1'h0;
    split = 1'h0;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge CLK);
    RST <= 1'h0;
    apb(1'h0, tmc_pkg::IDX_CLK_CTRL, 8'h00);
    cmp("clock control reset", 32'h0, rdv);
    apb(1'h1, tmc_pkg::IDX_CLK_CTRL, 8'hA5);
    apb(1'h0, tmc_pkg::IDX_CLK_CTRL, 8'h00);
    cmp("clock control rw", 32'hA5, rdv);
    apb(1'h0, 8'h00, 8'h00);
    cmp("unmapped err", 32'h1, 32'(err));
    cmp("unmapped data", 32'h0, rdv);
    apb(1'h1, tmc_pkg::IDX_MODE, 8'h00);
    // Count over a fixed window for every prescale and sysclk select
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 5; i++) begin
        apb(1'h1, tmc_pkg::IDX_CLK_CTRL, (i < 4) ? 8'(i) : (8'h02 | (8'h04 << t)));
        load(t, 8'h00, 8'h00);
        apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h10 << (2 * t));
        repeat (477) @(posedge CLK);
        apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h00);
        rd_cnt(t);
        cmp_rng("prescaled count", 480 / divs[i] - 1, 480 / divs[i] + 1, 32'(cnt));
      end
    end
    // Rollover, flag, interrupt and acknowledge
    apb(1'h1, tmc_pkg::IDX_IRQ_ENABLE, 8'h03);
    apb(1'h1, tmc_pkg::IDX_CLK_CTRL, 8'h0C);
    for (int t = 0; t < 2; t++) begin
      load(t, 8'hFF, 8'h1F);
      apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h10 << (2 * t));
      for (int n = 0; n < 40 && irq[t] !== 1'h1; n++) @(posedge CLK);
      cmp("overflow irq", 32'h1, 32'(irq[t]));
      apb(1'h0, tmc_pkg::IDX_RUN_FLAG, 8'h00);
      cmp("flag set", 32'(8'h30 << (2 * t)), rdv);
      @(posedge CLK);
      ack[t] <= 1'h1;
      @(posedge CLK);
      ack[t] <= 1'h0;
      apb(1'h0, tmc_pkg::IDX_RUN_FLAG, 8'h00);
      cmp("flag after ack", 32'(8'h10 << (2 * t)), rdv);
      cmp("irq after ack", 32'h0, 32'(irq[t]));
      apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h00);
    end
    // Pin counting under gate control; sysclk selects stay set and must be ignored
    apb(1'h1, tmc_pkg::IDX_IRQ_CONFIG, 8'h01);
    for (int t = 0; t < 2; t++) begin
      apb(1'h1, tmc_pkg::IDX_MODE, 8'h0C << (4 * t));
      load(t, 8'h01, 8'hFE);
      apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h10 << (2 * t));
      tmc_pin_model_inst.pulses(t, 3);
      repeat (8) @(posedge CLK);
      rd_cnt(t);
      cmp("gated off count", 32'h3E, 32'(cnt));
      tmc_pin_model_inst.set_gates(t == 0, t == 0);
      tmc_pin_model_inst.pulses(t, 4);
      repeat (8) @(posedge CLK);
      rd_cnt(t);
      cmp("pin count carry", 32'h42, 32'(cnt));
      apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h00);
      apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h10 << (2 * t));
      rd_cnt(t);
      cmp("count kept on run", 32'h42, 32'(cnt));
      apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h00);
      tmc_pin_model_inst.set_gates(1'h0, 1'h1);
    end
    // Modes other than 13-bit hold their count in this block
    apb(1'h1, tmc_pkg::IDX_MODE, 8'h11);
    load(0, 8'h00, 8'h05);
    apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h50);
    repeat (20) @(posedge CLK);
    apb(1'h1, tmc_pkg::IDX_RUN_FLAG, 8'h00);
    rd_cnt(0);
    cmp("other mode holds", 32'h05, 32'(cnt));
    // Timer 2 and 3 clock enables for each select, split and source
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      split   <= (i != 1);
      ext_sel <= (i == 3);
      apb(1'h1, tmc_pkg::IDX_CLK_CTRL, (i < 2) ? 8'hF0 : 8'h00);
      repeat (4) @(posedge CLK);
      tc = '{0, 0, 0, 0};
      repeat (tw[i]) begin
        @(posedge CLK);
        for (int k = 0; k < 4; k++) tc[k] += (tick[k] === 1'h1);
      end
      for (int k = 0; k < 4; k++) begin
        cmp_rng("tick count", ((k % 2 == 1) ? thi[i] : tlo[i]) - (i > 1),
                ((k % 2 == 1) ? thi[i] : tlo[i]) + (i > 1), 32'(tc[k]));
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
